// File: verilog/igp_general_io.sv
// Purpose: Two programmable general pins, their registers and pin sharing
// Assumes: ISA strobes and pins synchronous to clk; extended mode decided
//          outside and presented as a level
// Notes:   Every output is registered, so pins follow the bus by one cycle
`timescale 1ns/1ps

module igp_general_io (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// ISA bus
	input  wire logic        aen,
	input  wire logic        iorN,
	input  wire logic        iowN,
	input  wire logic [10:0] sa,
	input  wire logic [7:0]  sdIn,
	output logic      [7:0]  sdOut,
	output logic      [7:0]  sdOe,
	// Extended-function mode level
	input  wire logic        extFuncEnable,
	// Power-on straps
	input  wire logic        uart2RtsStrap,
	input  wire logic        uart2TxdStrap,
	// Interrupt sources sharing the general pins
	input  wire logic        irqARequest,
	input  wire logic        irqBRequest,
	// Shared pin carrying IRQ B or general pin A
	input  wire logic        pinAShareIn,
	output logic             pinAShareOut,
	output logic             pinAShareOe,
	// Shared pin carrying IRQ A or general pin B
	input  wire logic        pinBShareIn,
	output logic             pinBShareOut,
	output logic             pinBShareOe,
	// DMA and game-port sources
	input  wire logic        dmaRequestOne,
	input  wire logic        gameWriteStrobeN,
	input  wire logic        gameReadStrobeN,
	output logic             dmaAcknowledgeOneN,
	// Shared pin carrying DMA request or game write strobe
	output logic             dmaReqPinOut,
	output logic             dmaReqPinOe,
	// Shared pin carrying DMA acknowledge or game read strobe
	input  wire logic        dmaAckPinIn,
	output logic             dmaAckPinOut,
	output logic             dmaAckPinOe
);
	// Configuration registers
	logic [7:0] extIndex;
	logic [7:0] pinAAddrLow;
	logic [7:0] pinAAddrHigh;
	logic [7:0] pinBAddrLow;
	logic [7:0] pinBAddrHigh;
	logic [7:0] generalPin0Config;
	logic [7:0] generalPin1Config;
	logic [7:0] pinSharingConfig;
	logic       strapPending;

	// Bus decode
	logic       writeStart;
	logic       atIndexPort;
	logic       atDataPort;
	logic       regWrite;
	logic       indexWrite;
	logic       regRead;
	logic       indexRead;
	logic       mappedIndex;
	logic [7:0] readValue;

	// Decoder results
	logic       aBusBit;
	logic       aBusOe;
	logic       aPinOut;
	logic       aPinOe;
	logic       bBusBit;
	logic       bBusOe;
	logic       bPinOut;
	logic       bPinOe;

	// Next values of the registered outputs
	logic [7:0] next_sdOut;
	logic [7:0] next_sdOe;

	igp_pin_cfg_if cfgA ();
	igp_pin_cfg_if cfgB ();

	// Start of each write strobe; a long strobe writes only once
	igp_strobe_edge u_wr_edge (
		.clk     (clk),
		.rst     (rst),
		.strobeN (iowN),
		.start   (writeStart)
	);

	// Port decode, only while the extended mode is open
	assign atIndexPort = ~aen && (sa == igp_pkg::INDEX_PORT_ADDR);
	assign atDataPort  = ~aen && (sa == igp_pkg::DATA_PORT_ADDR);
	assign indexWrite  = writeStart && atIndexPort && extFuncEnable;
	assign regWrite    = writeStart && atDataPort && extFuncEnable;
	assign indexRead   = ~iorN && atIndexPort && extFuncEnable;
	assign regRead     = ~iorN && atDataPort && extFuncEnable && mappedIndex;

	// Index register of the extended port
	always_ff @(posedge clk) begin
		if (rst) begin
			extIndex <= igp_pkg::RST_INDEX;
		end else if (indexWrite) begin
			extIndex <= sdIn;
		end
	end

	// Address registers of both pins
	always_ff @(posedge clk) begin
		if (rst) begin
			pinAAddrLow  <= igp_pkg::RST_ADDR_LO;
			pinAAddrHigh <= igp_pkg::RST_ADDR_HI;
			pinBAddrLow  <= igp_pkg::RST_ADDR_LO;
			pinBAddrHigh <= igp_pkg::RST_ADDR_HI;
		end else if (regWrite) begin
			case (extIndex)
				igp_pkg::IDX_PIN_A_ADDR_LO: begin
					pinAAddrLow <= sdIn;
				end
				igp_pkg::IDX_PIN_A_ADDR_HI: begin
					pinAAddrHigh <= sdIn & igp_pkg::ADDR_HI_WMASK;
				end
				igp_pkg::IDX_PIN_B_ADDR_LO: begin
					pinBAddrLow <= sdIn;
				end
				igp_pkg::IDX_PIN_B_ADDR_HI: begin
					pinBAddrHigh <= sdIn & igp_pkg::ADDR_HI_WMASK;
				end
				default: begin
				end
			endcase
		end
	end

	// Mode registers of both pins
	always_ff @(posedge clk) begin
		if (rst) begin
			generalPin0Config <= igp_pkg::RST_PIN_CONFIG;
			generalPin1Config <= igp_pkg::RST_PIN_CONFIG;
		end else if (regWrite) begin
			if (extIndex == igp_pkg::IDX_PIN_A_CONFIG) begin
				generalPin0Config <= sdIn;
			end
			if (extIndex == igp_pkg::IDX_PIN_B_CONFIG) begin
				generalPin1Config <= sdIn;
			end
		end
	end

	// Pin-sharing register. Straps are caught in the first cycle after
	// reset release, since a reset may only load constants.
	always_ff @(posedge clk) begin
		if (rst) begin
			pinSharingConfig <= igp_pkg::RST_PIN_SHARING;
			strapPending     <= 1'b1;
		end else if (strapPending) begin
			strapPending <= 1'b0;
			pinSharingConfig[igp_pkg::SEL_GAME_BIT]  <= uart2TxdStrap;
			pinSharingConfig[igp_pkg::SEL_PIN_B_BIT] <= ~uart2RtsStrap;
			pinSharingConfig[igp_pkg::SEL_PIN_A_BIT] <= ~uart2RtsStrap;
		end else if (regWrite && extIndex == igp_pkg::IDX_PIN_SHARING) begin
			pinSharingConfig <= sdIn & igp_pkg::SHARING_WMASK;
		end
	end

	// Read mux over the mapped indices
	always_comb begin
		mappedIndex = 1'b1;
		readValue   = 8'h00;
		case (extIndex)
			igp_pkg::IDX_PIN_A_ADDR_LO: readValue = pinAAddrLow;
			igp_pkg::IDX_PIN_A_ADDR_HI: readValue = pinAAddrHigh;
			igp_pkg::IDX_PIN_B_ADDR_LO: readValue = pinBAddrLow;
			igp_pkg::IDX_PIN_B_ADDR_HI: readValue = pinBAddrHigh;
			igp_pkg::IDX_PIN_A_CONFIG:  readValue = generalPin0Config;
			igp_pkg::IDX_PIN_B_CONFIG:  readValue = generalPin1Config;
			igp_pkg::IDX_PIN_SHARING:   readValue = pinSharingConfig;
			default: mappedIndex = 1'b0;
		endcase
	end

	// Pin A configuration fields
	assign cfgA.mode         =
		generalPin0Config[igp_pkg::MODE_MSB:igp_pkg::MODE_LSB];
	assign cfgA.csPolarity   = generalPin0Config[igp_pkg::POLARITY_BIT];
	assign cfgA.readQual     = generalPin0Config[igp_pkg::READ_QUAL];
	assign cfgA.writeQual    = generalPin0Config[igp_pkg::WRITE_QUAL];
	assign cfgA.outInvert    = generalPin0Config[igp_pkg::OUT_INV_BIT];
	assign cfgA.inInvert     = generalPin0Config[igp_pkg::IN_INV_BIT];
	assign cfgA.cmpMode      =
		pinAAddrHigh[igp_pkg::CMP_MODE_MSB:igp_pkg::CMP_MODE_LSB];
	assign cfgA.matchAddress =
		{pinAAddrHigh[igp_pkg::ADDR_HI_MSB:0], pinAAddrLow};

	// Pin B configuration fields
	assign cfgB.mode         =
		generalPin1Config[igp_pkg::MODE_MSB:igp_pkg::MODE_LSB];
	assign cfgB.csPolarity   = generalPin1Config[igp_pkg::POLARITY_BIT];
	assign cfgB.readQual     = generalPin1Config[igp_pkg::READ_QUAL];
	assign cfgB.writeQual    = generalPin1Config[igp_pkg::WRITE_QUAL];
	assign cfgB.outInvert    = generalPin1Config[igp_pkg::OUT_INV_BIT];
	assign cfgB.inInvert     = generalPin1Config[igp_pkg::IN_INV_BIT];
	assign cfgB.cmpMode      =
		pinBAddrHigh[igp_pkg::CMP_MODE_MSB:igp_pkg::CMP_MODE_LSB];
	assign cfgB.matchAddress =
		{pinBAddrHigh[igp_pkg::ADDR_HI_MSB:0], pinBAddrLow};

	// Pin A bridges data bit 0
	igp_pin_decoder u_pin_a (
		.cfg    (cfgA.sink),
		.aen    (aen),
		.iorN   (iorN),
		.iowN   (iowN),
		.sa     (sa),
		.sdBit  (sdIn[0]),
		.busBit (aBusBit),
		.busOe  (aBusOe),
		.pinIn  (pinAShareIn),
		.pinOut (aPinOut),
		.pinOe  (aPinOe)
	);

	// Pin B bridges data bit 1
	igp_pin_decoder u_pin_b (
		.cfg    (cfgB.sink),
		.aen    (aen),
		.iorN   (iorN),
		.iowN   (iowN),
		.sa     (sa),
		.sdBit  (sdIn[1]),
		.busBit (bBusBit),
		.busOe  (bBusOe),
		.pinIn  (pinBShareIn),
		.pinOut (bPinOut),
		.pinOe  (bPinOe)
	);

	// Data bus drive. A register read owns the whole byte; otherwise a
	// general pin may drive its bit only while routed to its pin.
	always_comb begin
		next_sdOut = 8'h00;
		next_sdOe  = 8'h00;
		if (indexRead) begin
			next_sdOut = extIndex;
			next_sdOe  = 8'hFF;
		end else if (regRead) begin
			next_sdOut = readValue;
			next_sdOe  = 8'hFF;
		end else begin
			if (pinSharingConfig[igp_pkg::SEL_PIN_A_BIT] && aBusOe) begin
				next_sdOut[0] = aBusBit;
				next_sdOe[0]  = 1'b1;
			end
			if (pinSharingConfig[igp_pkg::SEL_PIN_B_BIT] && bBusOe) begin
				next_sdOut[1] = bBusBit;
				next_sdOe[1]  = 1'b1;
			end
		end
	end

	// Registered data bus outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			sdOut <= 8'h00;
			sdOe  <= 8'h00;
		end else begin
			sdOut <= next_sdOut;
			sdOe  <= next_sdOe;
		end
	end

	// Shared pins of the general pins and interrupt requests
	always_ff @(posedge clk) begin
		if (rst) begin
			pinAShareOut <= 1'b0;
			pinAShareOe  <= 1'b0;
			pinBShareOut <= 1'b0;
			pinBShareOe  <= 1'b0;
		end else begin
			if (pinSharingConfig[igp_pkg::SEL_PIN_A_BIT]) begin
				pinAShareOut <= aPinOut;
				pinAShareOe  <= aPinOe;
			end else begin
				pinAShareOut <= irqBRequest;
				pinAShareOe  <= 1'b1;
			end
			if (pinSharingConfig[igp_pkg::SEL_PIN_B_BIT]) begin
				pinBShareOut <= bPinOut;
				pinBShareOe  <= bPinOe;
			end else begin
				pinBShareOut <= irqARequest;
				pinBShareOe  <= 1'b1;
			end
		end
	end

	// DMA or game-strobe pins; acknowledge reads inactive when unrouted
	always_ff @(posedge clk) begin
		if (rst) begin
			dmaReqPinOut       <= 1'b0;
			dmaReqPinOe        <= 1'b0;
			dmaAckPinOut       <= 1'b1;
			dmaAckPinOe        <= 1'b0;
			dmaAcknowledgeOneN <= 1'b1;
		end else begin
			dmaReqPinOe <= 1'b1;
			if (pinSharingConfig[igp_pkg::SEL_GAME_BIT]) begin
				dmaReqPinOut       <= gameWriteStrobeN;
				dmaAckPinOut       <= gameReadStrobeN;
				dmaAckPinOe        <= 1'b1;
				dmaAcknowledgeOneN <= 1'b1;
			end else begin
				dmaReqPinOut       <= dmaRequestOne;
				dmaAckPinOut       <= 1'b1;
				dmaAckPinOe        <= 1'b0;
				dmaAcknowledgeOneN <= dmaAckPinIn;
			end
		end
	end
endmodule // igp_general_io

// File: verilog/igp_pkg.sv
// Purpose: Shared constants for the general-purpose pin decoder block
// Assumes: Registers reached through the extended index and data ports
// Notes:   Offsets are extended register indices, not bus addresses
package igp_pkg;
	// ISA port addresses of the extended index and data ports
	localparam logic [10:0] INDEX_PORT_ADDR = 11'h3F0;
	localparam logic [10:0] DATA_PORT_ADDR  = 11'h3F1;

	// Extended register indices
	localparam logic [7:0] IDX_PIN_A_ADDR_LO = 8'h10;
	localparam logic [7:0] IDX_PIN_A_ADDR_HI = 8'h11;
	localparam logic [7:0] IDX_PIN_B_ADDR_LO = 8'h12;
	localparam logic [7:0] IDX_PIN_B_ADDR_HI = 8'h13;
	localparam logic [7:0] IDX_PIN_A_CONFIG  = 8'h14;
	localparam logic [7:0] IDX_PIN_B_CONFIG  = 8'h15;
	localparam logic [7:0] IDX_PIN_SHARING   = 8'h16;

	// Reset values
	localparam logic [7:0] RST_ADDR_LO     = 8'h00;
	localparam logic [7:0] RST_ADDR_HI     = 8'h00;
	localparam logic [7:0] RST_PIN_CONFIG  = 8'h00;
	localparam logic [7:0] RST_PIN_SHARING = 8'h0E;
	localparam logic [7:0] RST_INDEX       = 8'h00;

	// Writable masks: reserved bits read as zero
	localparam logic [7:0] ADDR_HI_WMASK  = 8'hC7;
	localparam logic [7:0] SHARING_WMASK  = 8'h3F;

	// Address-high register fields
	localparam int CMP_MODE_MSB = 7;
	localparam int CMP_MODE_LSB = 6;
	localparam int ADDR_HI_MSB  = 2;

	// Pin configuration register fields
	localparam int MODE_MSB     = 7;
	localparam int MODE_LSB     = 5;
	localparam int POLARITY_BIT = 4;
	localparam int READ_QUAL    = 3;
	localparam int WRITE_QUAL   = 2;
	localparam int OUT_INV_BIT  = 1;
	localparam int IN_INV_BIT   = 0;

	// Pin modes (top bit set means chip select)
	localparam logic [2:0] MODE_OFF   = 3'h0;
	localparam logic [1:0] DMODE_OUT  = 2'h1;
	localparam logic [1:0] DMODE_IN   = 2'h2;
	localparam logic [1:0] DMODE_BIDI = 2'h3;

	// Pin-sharing register fields
	localparam int SEL_PIN_B_BIT = 5;
	localparam int SEL_PIN_A_BIT = 4;
	localparam int SEL_GAME_BIT  = 3;
endpackage

// File: verilog/igp_pin_cfg_if.sv
// Purpose: Carries one general pin's configuration to its decoder
// Assumes: Driven continuously from the configuration registers
// Notes:   One instance per general pin
`timescale 1ns/1ps
interface igp_pin_cfg_if;
	logic [2:0]  mode;
	logic        csPolarity;
	logic        readQual;
	logic        writeQual;
	logic        outInvert;
	logic        inInvert;
	logic [1:0]  cmpMode;
	logic [10:0] matchAddress;
	modport src  (output mode, csPolarity, readQual, writeQual,
		outInvert, inInvert, cmpMode, matchAddress);
	modport sink (input mode, csPolarity, readQual, writeQual,
		outInvert, inInvert, cmpMode, matchAddress);
endinterface // igp_pin_cfg_if

// File: verilog/igp_strobe_edge.sv
// Purpose: Finds the first cycle of an active-low bus strobe
// Assumes: Strobe already synchronous to clk
// Notes:   Idle state is high, so no false start out of reset
`timescale 1ns/1ps
module igp_strobe_edge (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Strobe
	input  wire logic strobeN,
	output logic      start
);
	logic prevN;

	// Remember last level
	always_ff @(posedge clk) begin
		if (rst) begin
			prevN <= 1'b1;
		end else begin
			prevN <= strobeN;
		end
	end

	assign start = prevN & ~strobeN;
endmodule // igp_strobe_edge

// File: verilog/igp_pin_decoder.sv
// Purpose: Address decode and data/chip-select logic of one general pin
// Assumes: Bus inputs synchronous to the clock; purely combinational
// Notes:   Caller registers the outputs
`timescale 1ns/1ps
module igp_pin_decoder (
	// Configuration
	igp_pin_cfg_if.sink cfg,
	// ISA side
	input  wire logic        aen,
	input  wire logic        iorN,
	input  wire logic        iowN,
	input  wire logic [10:0] sa,
	input  wire logic        sdBit,
	output logic             busBit,
	output logic             busOe,
	// Pin side
	input  wire logic        pinIn,
	output logic             pinOut,
	output logic             pinOe
);
	logic [10:0] cmpMask;
	logic        selected;
	logic        qualOk;

	// Low address bits dropped by the compare mode
	assign cmpMask  = 11'h7FF << cfg.cmpMode;
	assign selected = ~aen && (((sa ^ cfg.matchAddress) & cmpMask) == 11'h000);

	// Strobe qualifier for chip-select use
	always_comb begin
		case ({cfg.readQual, cfg.writeQual})
			2'b00: qualOk = 1'b1;
			2'b01: qualOk = ~iowN;
			2'b10: qualOk = ~iorN;
			default: qualOk = ~iowN | ~iorN;
		endcase
	end

	// Mode decode; unused fields of other modes are ignored
	always_comb begin
		pinOut = 1'b0;
		pinOe  = 1'b0;
		busBit = 1'b0;
		busOe  = 1'b0;
		if (cfg.mode[2]) begin
			pinOe  = 1'b1;
			pinOut = cfg.csPolarity ? (selected & qualOk)
				: ~(selected & qualOk);
		end else if (cfg.mode != igp_pkg::MODE_OFF) begin
			if ((cfg.mode[1:0] == igp_pkg::DMODE_OUT ||
				cfg.mode[1:0] == igp_pkg::DMODE_BIDI) && selected && ~iowN) begin
				pinOe  = 1'b1;
				pinOut = sdBit ^ cfg.outInvert;
			end
			if ((cfg.mode[1:0] == igp_pkg::DMODE_IN ||
				cfg.mode[1:0] == igp_pkg::DMODE_BIDI) && selected && ~iorN) begin
				busOe  = 1'b1;
				busBit = pinIn ^ cfg.inInvert;
			end
		end
	end
endmodule // igp_pin_decoder

// File: test/igp_general_io_props.sv
// Purpose: Port-level checks on the general pin decoder
// Assumes: Straps stay steady through reset; registers shadowed from bus
// Notes:   Only pin B, the data bus and the sharing outputs are followed here
`timescale 1ns/1ps
module igp_general_io_props (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// ISA bus
	input  wire logic        aen,
	input  wire logic        iorN,
	input  wire logic        iowN,
	input  wire logic [10:0] sa,
	input  wire logic [7:0]  sdIn,
	input  wire logic [7:0]  sdOut,
	input  wire logic [7:0]  sdOe,
	input  wire logic        extFuncEnable,
	// Straps and routed sources
	input  wire logic        uart2RtsStrap,
	input  wire logic        uart2TxdStrap,
	input  wire logic        irqARequest,
	input  wire logic        gameWriteStrobeN,
	// Pins
	input  wire logic        pinBShareIn,
	input  wire logic        pinBShareOut,
	input  wire logic        pinBShareOe,
	input  wire logic        dmaReqPinOut
);
	logic [7:0]  idx;
	logic [7:0]  shd [0:7];
	logic [7:0]  cfgB;
	logic        iowPrev;
	logic        strapWait;
	logic        wrEdge;
	logic        hitB;
	logic        csB;
	logic [10:0] diffB;

	// Write taken on the falling strobe, as the block takes it
	assign wrEdge = !aen && extFuncEnable && !iowN && iowPrev;
	assign cfgB = shd[5];
	assign diffB = (sa ^ {shd[3][2:0], shd[2]}) & (11'h7FF << shd[3][7:6]);
	assign hitB = !aen && diffB == 11'h000;
	assign csB = hitB && (cfgB[3:2] == 2'h0 || (cfgB[2] && !iowN)
		|| (cfgB[3] && !iorN));

	// Shadow of index and registers 10H..17H. Straps land one edge after
	// reset, as in the block, so routing lags release by that edge.
	always_ff @(posedge clk) begin
		iowPrev <= iowN;
		if (rst) begin
			idx       <= 8'h00;
			strapWait <= 1'b1;
			for (int i = 0; i < 8; i++) begin
				shd[i] <= (i == 6) ? igp_pkg::RST_PIN_SHARING : 8'h00;
			end
		end else if (strapWait) begin
			strapWait   <= 1'b0;
			shd[6][5:3] <= {!uart2RtsStrap, !uart2RtsStrap, uart2TxdStrap};
		end else if (wrEdge && sa == igp_pkg::INDEX_PORT_ADDR) begin
			idx <= sdIn;
		end else if (wrEdge && sa == igp_pkg::DATA_PORT_ADDR
			&& idx[7:3] == 5'h02) begin
			shd[idx[2:0]] <= sdIn;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_aen_quiet: assert property (
		aen |=> sdOe == 8'h00) else $error("bus driven with aen high");
	a_read_release: assert property (
		iorN |=> sdOe == 8'h00) else $error("bus held after read ended");
	a_cfg_read: assert property (
		!aen && extFuncEnable && !iorN && sa == igp_pkg::DATA_PORT_ADDR
		&& idx == igp_pkg::IDX_PIN_B_CONFIG |=> sdOe == 8'hFF
		&& sdOut == $past(cfgB)) else $error("pin B config read wrong");
	a_b_off: assert property (
		shd[6][5] && cfgB[7:5] == 3'h0 [*2] |-> !pinBShareOe)
		else $error("pin B driven while off");
	a_b_sel_oe: assert property (
		shd[6][5] && cfgB[7] |=> pinBShareOe)
		else $error("pin B select not driven");
	a_b_sel_level: assert property (
		shd[6][5] && cfgB[7] |=> pinBShareOut == ($past(csB) == $past(cfgB[4])))
		else $error("pin B select level wrong");
	a_b_write_out: assert property (
		shd[6][5] && cfgB[7:5] == 3'h1 && hitB && !iowN |=> pinBShareOe
		&& pinBShareOut == ($past(sdIn[1]) ^ $past(cfgB[1])))
		else $error("pin B output data wrong");
	a_b_bidi_write: assert property (
		shd[6][5] && cfgB[7:5] == 3'h3 && hitB && !iowN |=> pinBShareOe)
		else $error("pin B bidirectional write not driven");
	a_b_read_in: assert property (
		shd[6][5] && cfgB[7:6] == 2'h1 && hitB && !iorN |=> sdOe[1]
		&& sdOut[1] == ($past(pinBShareIn) ^ $past(cfgB[0])))
		else $error("pin B input data wrong");
	a_irq_route: assert property (
		!shd[6][5] |=> pinBShareOut == $past(irqARequest))
		else $error("interrupt not on shared pin");
	a_game_route: assert property (
		shd[6][3] |=> dmaReqPinOut == $past(gameWriteStrobeN))
		else $error("game write strobe not routed");
endmodule // igp_general_io_props

// File: test/igp_pin_partner.sv
// Purpose: Peripheral logic hanging on the two general pins
// Assumes: No pull resistors on these pins
// Notes:   Block drive wins; the bench commands the peripheral's drive
`timescale 1ns/1ps
module igp_pin_partner (
	// Clock
	input  wire logic       clk,
	// Block side of the pins
	input  wire logic [1:0] blkOut,
	input  wire logic [1:0] blkOe,
	// Peripheral drive
	input  wire logic [1:0] drvEn,
	input  wire logic [1:0] drvVal,
	// Resolved levels
	output logic      [1:0] pinLevel
);
	logic toggle = 1'h0;

	// Floating pin wanders, so show a changing level rather than a stale one
	always_ff @(posedge clk) begin
		toggle <= !toggle;
	end

	// Wire level from both parties' enables
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			pinLevel[i] = blkOe[i] ? blkOut[i] : (drvEn[i] ? drvVal[i] : toggle);
		end
	end
endmodule // igp_pin_partner

// File: test/igp_testbench.sv
// Purpose: Register and pin scenarios for the general pin decoder
// Assumes: Straps start RTS low, TXD high; a late reset flips both
// Notes:   Each bus step checks after the registered answer lands
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
	logic        clk = 1'h0;
	logic        rst, aen, iorN, iowN, extFuncEnable, act;
	logic        rtsStrap, txdStrap;
	logic [10:0] sa;
	logic [7:0]  sdIn, sdOut, sdOe;
	logic        irqA, irqB, dmaReq, gameWrN, gameRdN, ackIn, ackN;
	logic        aOut, aOe, bOut, bOe, reqOut, reqOe, ackOut, ackOe;
	logic [1:0]  drvEn, drvVal, level;
	logic [10:0] adr [0:1];
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          p, m, c, k;

	igp_general_io DUT (.clk(clk), .rst(rst), .aen(aen), .iorN(iorN),
		.iowN(iowN), .sa(sa), .sdIn(sdIn), .sdOut(sdOut), .sdOe(sdOe),
		.extFuncEnable(extFuncEnable), .uart2RtsStrap(rtsStrap),
		.uart2TxdStrap(txdStrap), .irqARequest(irqA), .irqBRequest(irqB),
		.pinAShareIn(level[0]), .pinAShareOut(aOut), .pinAShareOe(aOe),
		.pinBShareIn(level[1]), .pinBShareOut(bOut), .pinBShareOe(bOe),
		.dmaRequestOne(dmaReq), .gameWriteStrobeN(gameWrN),
		.gameReadStrobeN(gameRdN), .dmaAcknowledgeOneN(ackN),
		.dmaReqPinOut(reqOut), .dmaReqPinOe(reqOe), .dmaAckPinIn(ackIn),
		.dmaAckPinOut(ackOut), .dmaAckPinOe(ackOe));
	igp_pin_partner u_partner (.clk(clk), .blkOut({bOut, aOut}),
		.blkOe({bOe, aOe}), .drvEn(drvEn), .drvVal(drvVal), .pinLevel(level));

	always #20 clk = ~clk;

	task automatic test_done();
		if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// One bus step from a falling edge to the next
	task automatic bus(input logic a, input logic [10:0] s, input logic w,
		input logic r, input logic [7:0] d);
		aen = a;
		sa = s;
		iowN = w;
		iorN = r;
		sdIn = d;
		@(posedge clk);
		@(negedge clk);
	endtask

	// Index then data port; strobe high one cycle between writes
	task automatic wr(input logic [7:0] i, input logic [7:0] v);
		bus(1'h0, igp_pkg::INDEX_PORT_ADDR, 1'h0, 1'h1, i);
		bus(1'h0, igp_pkg::INDEX_PORT_ADDR, 1'h1, 1'h1, i);
		bus(1'h0, igp_pkg::DATA_PORT_ADDR, 1'h0, 1'h1, v);
		bus(1'h0, igp_pkg::DATA_PORT_ADDR, 1'h1, 1'h1, v);
	endtask

	task automatic rd(input logic [7:0] i, input logic [7:0] oe,
		input logic [7:0] v);
		bus(1'h0, igp_pkg::INDEX_PORT_ADDR, 1'h0, 1'h1, i);
		bus(1'h0, igp_pkg::INDEX_PORT_ADDR, 1'h1, 1'h1, i);
		bus(1'h0, igp_pkg::DATA_PORT_ADDR, 1'h1, 1'h0, 8'h00);
		`CHK(sdOe, oe)
		if (oe != 8'h00) `CHK(sdOut, v)
		bus(1'h0, igp_pkg::DATA_PORT_ADDR, 1'h1, 1'h1, 8'h00);
	endtask

	task automatic pchk(input int q, input logic oe, input logic v);
		`CHK(q ? bOe : aOe, oe)
		if (oe) `CHK(q ? bOut : aOut, v)
	endtask

	// Main sequence
	initial begin
		rst = 1'h1; aen = 1'h1; iorN = 1'h1; iowN = 1'h1; sa = 11'h000;
		sdIn = 8'h00; extFuncEnable = 1'h1; irqA = 1'h0; irqB = 1'h0;
		dmaReq = 1'h0; gameWrN = 1'h1; gameRdN = 1'h1; ackIn = 1'h1;
		drvEn = 2'h3; drvVal = 2'h2; adr[0] = 11'h2A5; adr[1] = 11'h300;
		rtsStrap = 1'h0; txdStrap = 1'h1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst = 1'h0;
		bus(1'h1, 11'h000, 1'h1, 1'h1, 8'h00);
		rd(igp_pkg::IDX_PIN_B_CONFIG, 8'hFF, 8'h00);
		rd(igp_pkg::IDX_PIN_SHARING, 8'hFF, 8'h3E);
		rd(8'h17, 8'h00, 8'h00);
		extFuncEnable = 1'h0;
		wr(igp_pkg::IDX_PIN_B_CONFIG, 8'hE0);
		extFuncEnable = 1'h1;
		rd(igp_pkg::IDX_PIN_B_CONFIG, 8'hFF, 8'h00);
		wr(8'h10, 8'hA5);
		wr(8'h11, 8'h02);
		wr(8'h12, 8'h00);
		wr(8'h13, 8'h03);
		// Chip select: every polarity and qualifier against each cycle kind
		for (p = 0; p < 2; p++) for (c = 0; c < 8; c++) begin
			wr(p ? 8'h15 : 8'h14, {1'h1, c[1:0], c[2:0], 2'h3});
			for (k = 0; k < 4; k++) begin
				bus(k == 3, adr[p], k != 1, k != 2, 8'hFF);
				act = k != 3 && (c[1:0] == 0 || (c[0] && k == 1)
					|| (c[1] && k == 2));
				pchk(p, 1'h1, act == c[2]);
			end
		end
		// Data modes with every inversion pair; select bits set but inert
		for (p = 0; p < 2; p++) for (m = 0; m < 4; m++) for (c = 0; c < 4; c++) begin
			wr(p ? 8'h15 : 8'h14, {m[2:0], 3'h7, c[1:0]});
			bus(1'h0, adr[p], 1'h0, 1'h1, 8'h03);
			pchk(p, m[0], !c[1]);
			bus(1'h0, adr[p], 1'h1, 1'h1, 8'h00);
			pchk(p, 1'h0, 1'h0);
			bus(1'h0, adr[p], 1'h1, 1'h0, 8'h00);
			`CHK(sdOe[p], m[1])
			if (m[1]) `CHK(sdOut[p], drvVal[p] ^ c[0])
		end
		// Compare mode 3 ignores the three low address bits
		wr(8'h13, 8'hC3);
		wr(igp_pkg::IDX_PIN_B_CONFIG, 8'h90);
		bus(1'h0, 11'h307, 1'h1, 1'h1, 8'h00);
		pchk(1, 1'h1, 1'h1);
		bus(1'h0, 11'h308, 1'h1, 1'h1, 8'h00);
		pchk(1, 1'h1, 1'h0);
		// Pin sharing in both settings
		wr(igp_pkg::IDX_PIN_SHARING, 8'h08);
		for (k = 0; k < 2; k++) begin
			irqA = k[0]; irqB = !k[0]; gameWrN = k[0]; gameRdN = !k[0];
			bus(1'h1, 11'h000, 1'h1, 1'h1, 8'h00);
			`CHK(bOut, k[0])
			`CHK(aOut, !k[0])
			`CHK(reqOut, k[0])
			`CHK(ackOut, !k[0])
			`CHK({reqOe, ackOe, ackN}, 3'h7)
		end
		wr(igp_pkg::IDX_PIN_SHARING, 8'h00);
		for (k = 0; k < 2; k++) begin
			dmaReq = k[0]; ackIn = !k[0];
			bus(1'h1, 11'h000, 1'h1, 1'h1, 8'h00);
			`CHK(reqOut, k[0])
			`CHK(ackN, !k[0])
			`CHK({reqOe, ackOe}, 2'h2)
		end
		wr(igp_pkg::IDX_PIN_SHARING, 8'hFF);
		rd(igp_pkg::IDX_PIN_SHARING, 8'hFF, 8'h3F);
		// Late reset with both straps flipped; pins drop, straps reload
		rtsStrap = 1'h1; txdStrap = 1'h0; rst = 1'h1;
		bus(1'h1, 11'h000, 1'h1, 1'h1, 8'h00);
		`CHK({aOe, bOe}, 2'h0)
		rst = 1'h0;
		bus(1'h1, 11'h000, 1'h1, 1'h1, 8'h00);
		rd(igp_pkg::IDX_PIN_SHARING, 8'hFF, 8'h06);
		rd(igp_pkg::IDX_PIN_B_CONFIG, 8'hFF, 8'h00);
		// Index port reads back the last index written
		bus(1'h0, igp_pkg::INDEX_PORT_ADDR, 1'h1, 1'h0, 8'h00);
		`CHK({sdOe, sdOut}, {8'hFF, igp_pkg::IDX_PIN_B_CONFIG})
		test_done();
	end

	// Watchdog: the sequence needs about 430 cycles; allow over twenty times
	initial begin
		#400000;
		error_cnt++;
		test_done();
	end
endmodule // testbench

bind igp_general_io igp_general_io_props u_props (.clk(clk), .rst(rst),
	.aen(aen), .iorN(iorN), .iowN(iowN), .sa(sa), .sdIn(sdIn),
	.sdOut(sdOut), .sdOe(sdOe), .extFuncEnable(extFuncEnable),
	.uart2RtsStrap(uart2RtsStrap), .uart2TxdStrap(uart2TxdStrap),
	.irqARequest(irqARequest), .gameWriteStrobeN(gameWriteStrobeN),
	.pinBShareIn(pinBShareIn), .pinBShareOut(pinBShareOut),
	.pinBShareOe(pinBShareOe), .dmaReqPinOut(dmaReqPinOut));
